// ===== dv/rarac_properties.sv
`timescale 1ns/1ps
module rarac_checker (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Bus side
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  // Receive side
  input wire rxFrameGood,
  input wire phyHeaderErrorFlag,
  input wire rxOn,
  input wire autoAckEnable,
  input wire ackFramePendingValue,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic cfgWr_q;
  logic autoRe_q;
  wire take = hsel && htrans[1] && hready;
  // Shadow of the re-enable bit, so event checks know the mode
  always @(posedge core_clk) begin
    cfgWr_q <= !reset && take && hwrite && haddr[7:0] == 8'h10;
    if (reset) autoRe_q <= 1'b0;
    else if (cfgWr_q) autoRe_q <= hwdata[29];
  end
  AST_AACK_RST: assert property (disable iff (1'b0) reset |=> !autoAckEnable)
    else $error("auto ack not cleared by reset");
  AST_PEND_RST: assert property (disable iff (1'b0) reset |=> !ackFramePendingValue)
    else $error("pending value not cleared by reset");
  AST_IRQ_RST: assert property (disable iff (1'b0) reset |=> !irq)
    else $error("irq not cleared by reset");
  AST_AACK_COPY: assert property (cfgWr_q |=> autoAckEnable == $past(hwdata[30]))
    else $error("auto ack does not follow config");
  AST_PEND_COPY: assert property (cfgWr_q |=> ackFramePendingValue == $past(hwdata[31]))
    else $error("pending value does not follow config");
  AST_AUTO_OFF: assert property (rxOn && !autoRe_q && (rxFrameGood || phyHeaderErrorFlag) |-> ##[1:2] !rxOn)
    else $error("receiver stayed on after event");
  AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  AST_OKAY: assert property (!hresp)
    else $error("response not okay");
endmodule

bind rxar_top rarac_checker rarac_checker_inst (.core_clk(core_clk), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .rxFrameGood(rxFrameGood),
  .phyHeaderErrorFlag(phyHeaderErrorFlag), .rxOn(rxOn), .autoAckEnable(autoAckEnable),
  .ackFramePendingValue(ackFramePendingValue), .irq(irq));

// ===== dv/rarac_rx_model.sv
`timescale 1ns/1ps
module rarac_rx_model (
  // Clock
  input wire core_clk,
  // Ack control
  input wire autoAckEnable,
  // Receive events
  output logic rxFrameGood = 1'b0,
  output logic rxAckRequest = 1'b0,
  output logic phyHeaderErrorFlag = 1'b0,
  output logic ackTxDone = 1'b0
);
  logic [3:0] ackCnt_q = 4'h0;
  // One receive outcome: good frame or header failure
  task automatic pulse(input logic good, input logic ack);
    @(posedge core_clk);
    rxFrameGood <= good;
    phyHeaderErrorFlag <= !good;
    rxAckRequest <= ack;
    @(posedge core_clk);
    rxFrameGood <= 1'b0;
    phyHeaderErrorFlag <= 1'b0;
    rxAckRequest <= 1'b0;
  endtask
  // Ack frame takes eight cycles on air, then reports done
  always @(posedge core_clk) begin
    ackTxDone <= ackCnt_q == 4'h1;
    if (ackCnt_q != 4'h0) ackCnt_q <= ackCnt_q - 4'h1;
    else if (rxFrameGood && rxAckRequest && autoAckEnable) ackCnt_q <= 4'h8;
  end
endmodule

// ===== dv/rx_auto_reenable_ack_config_tb.sv
`timescale 1ns/1ps
module rx_auto_reenable_ack_config_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hreadyout, hresp, irq, rxOn, autoAckEnable, ackFramePendingValue;
  wire rxFrameGood, rxAckRequest, phyHeaderErrorFlag, ackTxDone;
  wire [31:0] hrdata;
  int failures = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic [31:0] val;

  rxar_top #(.UNIT_CYC(2)) rxar_top_inst (.core_clk(core_clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rxFrameGood(rxFrameGood), .rxAckRequest(rxAckRequest), .phyHeaderErrorFlag(phyHeaderErrorFlag),
    .ackTxDone(ackTxDone), .rxOn(rxOn), .autoAckEnable(autoAckEnable),
    .ackFramePendingValue(ackFramePendingValue), .irq(irq));
  rarac_rx_model rarac_rx_model_inst (.core_clk(core_clk), .autoAckEnable(autoAckEnable),
    .rxFrameGood(rxFrameGood), .rxAckRequest(rxAckRequest), .phyHeaderErrorFlag(phyHeaderErrorFlag),
    .ackTxDone(ackTxDone));

  initial forever #12.5 core_clk = ~core_clk;

  task automatic test_done();
    if (failures == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for ready, so a stuck slave ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        test_done();
      end
      @(posedge core_clk);
    end
  endtask

  // Single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitRdy();
    rd = hrdata;
  endtask

  // Receiver state expected after one event
  function automatic logic expRx(input logic dbl, input logic autr, input logic good);
    return autr && (dbl || !good);
  endfunction

  initial begin
    void'($urandom(32'heefd));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, ackFramePendingValue, autoAckEnable}, 32'h0);
    repeat (4) begin
      val = $urandom() & 32'hf07fffff;
      bus(1'b1, 8'h10, val);
      bus(1'b0, 8'h10, 32'h0);
      chk(rd, val);
      chk({30'h0, ackFramePendingValue, autoAckEnable}, {30'h0, val[31:30]});
    end
    // Unmapped place ignores writes
    bus(1'b1, 8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h44, 32'h7);
    // explicit enable for each re-enable and double buffer setting, with a good frame and a header error
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h10, {2'h0, m[1], 29'h0});
      bus(1'b1, 8'h34, {30'h0, m[0], 1'b1});
      repeat (4) @(posedge core_clk);
      chk({31'h0, rxOn}, 32'h1);
      rarac_rx_model_inst.pulse(m[2], 1'b0);
      repeat (3) @(posedge core_clk);
      chk({31'h0, rxOn}, {31'h0, expRx(m[0], m[1], m[2])});
    end
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h3);
    repeat (3) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    // Double buffer with auto ack holds off until ack sent
    bus(1'b1, 8'h10, 32'h60000000);
    bus(1'b1, 8'h34, 32'h3);
    // Enable command bit reads back as zero
    bus(1'b0, 8'h34, 32'h0);
    chk(rd, 32'h2);
    repeat (4) @(posedge core_clk);
    rarac_rx_model_inst.pulse(1'b1, 1'b1);
    repeat (3) @(posedge core_clk);
    chk({31'h0, rxOn}, 32'h0);
    // State shows the wait for the ack frame
    bus(1'b0, 8'h50, 32'h0);
    chk(rd, 32'h2);
    repeat (12) @(posedge core_clk);
    chk({31'h0, rxOn}, 32'h1);
    bus(1'b0, 8'h50, 32'h0);
    chk(rd, 32'h1);
    // Timeout masked off, and no re-enable after it
    bus(1'b1, 8'h44, 32'h3);
    bus(1'b1, 8'h30, 32'h8);
    bus(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h8);
    bus(1'b1, 8'h10, 32'h30000000);
    bus(1'b0, 8'h3c, 32'h0);
    bus(1'b1, 8'h34, 32'h3);
    repeat (40) @(posedge core_clk);
    chk({31'h0, rxOn}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h4);
    // A frame before expiry stops the count
    bus(1'b1, 8'h10, 32'h10000000);
    bus(1'b1, 8'h34, 32'h1);
    repeat (3) @(posedge core_clk);
    rarac_rx_model_inst.pulse(1'b1, 1'b0);
    repeat (40) @(posedge core_clk);
    bus(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h1);
    test_done();
  end
endmodule

// ===== hdl/rxar_defs.vh
`ifndef RXAR_DEFS_VH
`define RXAR_DEFS_VH

// Register indices; each register owns one aligned word
`define RXAR_IDX_CFG 8'h04
`define RXAR_IDX_PERIOD 8'h0c
`define RXAR_IDX_CTRL 8'h0d
`define RXAR_IDX_STATUS 8'h0f
`define RXAR_IDX_MASK 8'h11
`define RXAR_IDX_STATE 8'h14

// Register byte offsets, four times the index
`define RXAR_OFS_CFG 8'h10
`define RXAR_OFS_PERIOD 8'h30
`define RXAR_OFS_CTRL 8'h34
`define RXAR_OFS_STATUS 8'h3c
`define RXAR_OFS_MASK 8'h44
`define RXAR_OFS_STATE 8'h50

// Configuration register fields
`define RXAR_CFG_RSVD_HI 27
`define RXAR_CFG_RSVD_LO 23
`define RXAR_CFG_WTOE 28
`define RXAR_CFG_AUTR 29
`define RXAR_CFG_AACK 30
`define RXAR_CFG_PEND 31
`define RXAR_CFG_RESET 32'h00000000

// Control register fields
`define RXAR_CTRL_RXEN 0
`define RXAR_CTRL_DBL 1
`define RXAR_CTRL_RESET 2'h0

// Event status and mask fields
`define RXAR_EV_GOOD 0
`define RXAR_EV_PHE 1
`define RXAR_EV_TMO 2
`define RXAR_EV_W 3
`define RXAR_MASK_RESET 3'h0

// State register fields
`define RXAR_ST_ON 0
`define RXAR_ST_ACKW 1

// Timeout period register
`define RXAR_PERIOD_W 16
`define RXAR_PERIOD_RESET 16'h0000

// Timeout period unit and core clock
`define RXAR_UNIT_NS 1000
`define RXAR_CLK_NS 25
`define RXAR_UNIT_CYC (`RXAR_UNIT_NS / `RXAR_CLK_NS)

`endif

// ===== hdl/rxar_event_irq.v
`timescale 1ns/1ps
`include "rxar_defs.vh"

module rxar_event_irq #(
  parameter EV_W = `RXAR_EV_W
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Event pulses
  input wire [EV_W-1:0] events,
  // Software access
  input wire readClear,
  input wire maskWrite,
  input wire [EV_W-1:0] maskData,
  // State
  output reg [EV_W-1:0] status,
  output reg [EV_W-1:0] mask,
  output reg irq
);

  wire [EV_W-1:0] statusNext;

  // A set in the clearing cycle survives the clear
  assign statusNext = (readClear ? {EV_W{1'b0}} : status) | events;

  // Sticky status, mask and level interrupt
  always @(posedge core_clk) begin
    if (reset) begin
      status <= {EV_W{1'b0}};
      mask <= `RXAR_MASK_RESET;
      irq <= 1'b0;
    end else begin
      status <= statusNext;
      if (maskWrite) begin
        mask <= maskData;
        irq <= |(statusNext & maskData);
      end else begin
        irq <= |(statusNext & mask);
      end
    end
  end

endmodule

// ===== hdl/rxar_top.v
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`include "rxar_defs.vh"

module rxar_top #(
  parameter PERIOD_W = `RXAR_PERIOD_W,
  parameter UNIT_CYC = `RXAR_UNIT_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Receive path events
  input wire rxFrameGood,
  input wire rxAckRequest,
  input wire phyHeaderErrorFlag,
  input wire ackTxDone,
  // Receiver and acknowledgement control
  output reg rxOn,
  output reg autoAckEnable,
  output reg ackFramePendingValue,
  // Interrupt
  output reg irq
);

  // Receiver states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_RX = 3'b010;
  localparam [2:0] ST_ACKW = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] cfg_q;
  reg [1:0] ctrl_q;
  reg [PERIOD_W-1:0] period_q;
  reg wrPend_q;
  reg rdPend_q;
  reg [7:0] addr_q;
  reg timerLoad;
  reg timerStop;
  reg [`RXAR_EV_W-1:0] events;
  wire addrAccept;
  wire wrDone;
  wire rdDone;
  wire cfgWrite;
  wire ctrlWrite;
  wire maskWrite;
  wire rxEnableCmd;
  wire statusRead;
  wire timerExpired;
  wire timerRunning;
  wire irqNext;
  wire [`RXAR_EV_W-1:0] status;
  wire [`RXAR_EV_W-1:0] mask;
  wire timeoutEnable;
  wire autoReenable;
  wire doubleBuffered;
  reg [31:0] rdMux;

  // Address phase accepted when selected, active transfer and bus ready
  assign addrAccept = hsel & htrans[1] & hready;
  assign wrDone = wrPend_q;
  // Reads take one wait state so pending writes land first
  assign rdDone = rdPend_q;

  assign cfgWrite = wrDone && (addr_q == `RXAR_OFS_CFG);
  assign ctrlWrite = wrDone && (addr_q == `RXAR_OFS_CTRL);
  assign maskWrite = wrDone && (addr_q == `RXAR_OFS_MASK);
  assign rxEnableCmd = ctrlWrite && hwdata[`RXAR_CTRL_RXEN];
  assign statusRead = rdDone && (addr_q == `RXAR_OFS_STATUS);

  assign timeoutEnable = cfg_q[`RXAR_CFG_WTOE];
  assign autoReenable = cfg_q[`RXAR_CFG_AUTR];
  assign doubleBuffered = ctrl_q[`RXAR_CTRL_DBL];

  // Bus phase tracking
  always @(posedge core_clk) begin
    if (reset) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rdPend_q) begin
        rdPend_q <= 1'b0;
        hreadyout <= 1'b1;
        wrPend_q <= 1'b0;
      end else if (addrAccept) begin
        addr_q <= haddr[7:0];
        wrPend_q <= hwrite;
        rdPend_q <= ~hwrite;
        hreadyout <= hwrite;
      end else begin
        wrPend_q <= 1'b0;
      end
    end
  end

  // Read data mux; unmapped addresses read as zero
  always @* begin
    rdMux = 32'h00000000;
    case (addr_q)
      `RXAR_OFS_CFG: rdMux = cfg_q;
      `RXAR_OFS_PERIOD: rdMux[PERIOD_W-1:0] = period_q;
      `RXAR_OFS_CTRL: rdMux[`RXAR_CTRL_DBL] = ctrl_q[`RXAR_CTRL_DBL];
      `RXAR_OFS_STATUS: rdMux[`RXAR_EV_W-1:0] = status;
      `RXAR_OFS_MASK: rdMux[`RXAR_EV_W-1:0] = mask;
      `RXAR_OFS_STATE: begin
        rdMux[`RXAR_ST_ON] = rxOn;
        rdMux[`RXAR_ST_ACKW] = state_q[2];
      end
      default: rdMux = 32'h00000000;
    endcase
  end

  // Read data register, loaded in the wait cycle
  always @(posedge core_clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (rdDone) begin
      hrdata <= rdMux;
    end
  end

  // Configuration, control and period registers
  always @(posedge core_clk) begin
    if (reset) begin
      cfg_q <= `RXAR_CFG_RESET;
      ctrl_q <= `RXAR_CTRL_RESET;
      period_q <= `RXAR_PERIOD_RESET;
    end else begin
      if (cfgWrite) begin
        cfg_q <= hwdata;
      end
      if (ctrlWrite) begin
        ctrl_q[`RXAR_CTRL_DBL] <= hwdata[`RXAR_CTRL_DBL];
      end
      if (wrDone && (addr_q == `RXAR_OFS_PERIOD)) begin
        period_q <= hwdata[PERIOD_W-1:0];
      end
    end
  end

  // Acknowledgement controls in their own flops, loaded in step with the configuration register
  always @(posedge core_clk) begin
    if (reset) begin
      autoAckEnable <= 1'b0;
      ackFramePendingValue <= 1'b0;
    end else begin
      autoAckEnable <= cfgWrite ? hwdata[`RXAR_CFG_AACK] : cfg_q[`RXAR_CFG_AACK];
      ackFramePendingValue <= cfgWrite ? hwdata[`RXAR_CFG_PEND] : cfg_q[`RXAR_CFG_PEND];
    end
  end

  // Receiver sequencing; a timeout outranks a frame in the same cycle
  always @* begin
    state_d = state_q;
    timerLoad = 1'b0;
    timerStop = 1'b0;
    events = {`RXAR_EV_W{1'b0}};
    case (state_q)
      ST_IDLE: begin
        if (rxEnableCmd) begin
          state_d = ST_RX;
          timerLoad = timeoutEnable;
        end
      end
      ST_RX: begin
        if (timerExpired) begin
          events[`RXAR_EV_TMO] = 1'b1;
          state_d = ST_IDLE;
        end else if (rxFrameGood) begin
          events[`RXAR_EV_GOOD] = 1'b1;
          timerStop = 1'b1;
          if (autoReenable && doubleBuffered) begin
            if (autoAckEnable && rxAckRequest) begin
              state_d = ST_ACKW;
            end else begin
              timerLoad = timeoutEnable;
            end
          end else begin
            state_d = ST_IDLE;
          end
        end else if (phyHeaderErrorFlag) begin
          events[`RXAR_EV_PHE] = 1'b1;
          if (autoReenable) begin
            timerLoad = timeoutEnable;
          end else begin
            state_d = ST_IDLE;
            timerStop = 1'b1;
          end
        end else if (rxEnableCmd) begin
          timerLoad = timeoutEnable;
          timerStop = ~timeoutEnable;
        end
      end
      ST_ACKW: begin
        if (ackTxDone) begin
          state_d = ST_RX;
          timerLoad = timeoutEnable;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register and receiver enable output
  always @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      rxOn <= 1'b0;
    end else begin
      state_q <= state_d;
      rxOn <= (state_d == ST_RX);
    end
  end

  // Frame wait down-counter
  rxar_wait_timer #(
    .PERIOD_W(PERIOD_W),
    .UNIT_CYC(UNIT_CYC)
  ) uTimer (
    .core_clk(core_clk),
    .reset(reset),
    .load(timerLoad),
    .stop(timerStop),
    .period(period_q),
    .expired(timerExpired),
    .running(timerRunning)
  );

  // Sticky events, mask and interrupt level
  rxar_event_irq #(
    .EV_W(`RXAR_EV_W)
  ) uIrq (
    .core_clk(core_clk),
    .reset(reset),
    .events(events),
    .readClear(statusRead),
    .maskWrite(maskWrite),
    .maskData(hwdata[`RXAR_EV_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irqNext)
  );

  // Interrupt output kept in a top-level flop
  always @(posedge core_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= irqNext;
    end
  end

endmodule

// ===== hdl/rxar_wait_timer.v
`timescale 1ns/1ps
`include "rxar_defs.vh"

module rxar_wait_timer #(
  parameter PERIOD_W = `RXAR_PERIOD_W,
  parameter UNIT_CYC = `RXAR_UNIT_CYC
) (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Control
  input wire load,
  input wire stop,
  input wire [PERIOD_W-1:0] period,
  // Result
  output reg expired,
  output reg running
);

  reg [15:0] preCnt_q;
  reg [PERIOD_W-1:0] count_q;

  // Prescaler gives one tick per period unit; restarts on load
  always @(posedge core_clk) begin
    if (reset) begin
      preCnt_q <= 16'h0000;
      count_q <= {PERIOD_W{1'b0}};
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        preCnt_q <= 16'h0000;
        count_q <= period;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (preCnt_q == UNIT_CYC[15:0] - 16'h0001) begin
          preCnt_q <= 16'h0000;
          // Zero period expires after one unit rather than never
          if (count_q <= {{(PERIOD_W-1){1'b0}}, 1'b1}) begin
            running <= 1'b0;
            expired <= 1'b1;
          end else begin
            count_q <= count_q - {{(PERIOD_W-1){1'b0}}, 1'b1};
          end
        end else begin
          preCnt_q <= preCnt_q + 16'h0001;
        end
      end
    end
  end

endmodule
